// ==== src/hbc_ctrl.v ====
`timescale 1ns/10ps
`include "hbc_map.vh"
// Operation
// - Fault cleared by enable high, low, high sequence
// - Power-on: sleep low, then sleep high, then enable high
// - Stop PWM inputs before logic supply removed; never above it
// - Parallel mode joins input A to B per channel
module hbc_ctrl #(
	parameter SUPPLY_WAIT_CYC = `HBC_SUPPLY_WAIT_CYC,
	parameter REG_WAIT_CYC = `HBC_REG_WAIT_CYC
) (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	// User side
	input wire power_on,
	input wire auto_recover,
	input wire parallel_mode,
	input wire ch1_a,
	input wire ch1_b,
	input wire ch2_a,
	input wire ch2_b,
	output reg running_r,
	output reg fault_seen_r,
	output reg warn_seen_r,
	output reg logic_ref_ok_r,
	// Device pins
	input wire fault_n,
	input wire overtemp_warn_n,
	output reg sleep_n,
	output reg bridge_en,
	output reg parallel_sel,
	output wire pwm1_in_a,
	output wire pwm1_in_b,
	output wire pwm2_in_a,
	output wire pwm2_in_b
);
	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	reg rst_meta_r;
	reg rst_n;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [`HBC_CNT_W-1:0] cnt_r;
	reg [`HBC_CNT_W-1:0] cnt_nxt;
	wire drive_nxt;
	wire sleep_nxt;
	wire bridge_en_nxt;
	wire logic_ref_nxt;
	// Low time of the clearing toggle, cut to the counter width
	localparam TOGGLE_LOW_CYC = `HBC_TOGGLE_LOW_CYC;
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		// Counter runs down by itself; states only load it
		if (cnt_r != {`HBC_CNT_W{1'b0}}) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		case (state_r)
			`HBC_ST_OFF: begin
				if (power_on) begin
					state_nxt = `HBC_ST_SUPPLY;
					cnt_nxt = SUPPLY_WAIT_CYC[`HBC_CNT_W-1:0];
				end
			end
			`HBC_ST_SUPPLY: begin
				if (!power_on) begin
					state_nxt = `HBC_ST_STOP;
				end else if (cnt_r == {`HBC_CNT_W{1'b0}}) begin
					state_nxt = `HBC_ST_REGWAIT;
					cnt_nxt = REG_WAIT_CYC[`HBC_CNT_W-1:0];
				end
			end
			`HBC_ST_REGWAIT: begin
				if (!power_on) begin
					state_nxt = `HBC_ST_STOP;
				end else if (cnt_r == {`HBC_CNT_W{1'b0}}) begin
					state_nxt = `HBC_ST_RUN;
				end
			end
			`HBC_ST_RUN: begin
				// Auto mode leaves clearing to the RC network, pins are only gated
				if (!power_on) begin
					state_nxt = `HBC_ST_STOP;
				end else if (!fault_n && !auto_recover) begin
					state_nxt = `HBC_ST_FAULT;
				end
			end
			`HBC_ST_FAULT: begin
				// Enable dropped to start the clearing toggle
				if (!power_on) begin
					state_nxt = `HBC_ST_STOP;
				end else begin
					state_nxt = `HBC_ST_REARM;
					cnt_nxt = TOGGLE_LOW_CYC[`HBC_CNT_W-1:0];
				end
			end
			`HBC_ST_REARM: begin
				// Enable rises again only after the full low time
				if (!power_on) begin
					state_nxt = `HBC_ST_STOP;
				end else if (cnt_r == {`HBC_CNT_W{1'b0}}) begin
					state_nxt = `HBC_ST_RUN;
				end
			end
			`HBC_ST_STOP: begin
				// Pins already idle; logic supply flag drops next cycle
				state_nxt = `HBC_ST_OFF;
			end
			default: begin
				state_nxt = `HBC_ST_OFF;
			end
		endcase
	end
	// ----------------------------------------
	// Next pin levels
	// ----------------------------------------
	// Pins gate on the same edge as enable, so no PWM edge trails a stop or fault
	assign drive_nxt = (state_nxt == `HBC_ST_RUN) & (state_r == `HBC_ST_RUN) & fault_n;
	// Sleep low through supply ramp, high after
	assign sleep_nxt = (state_nxt != `HBC_ST_OFF) & (state_nxt != `HBC_ST_SUPPLY)
		& (state_nxt != `HBC_ST_STOP);
	// Auto mode: fault line drags enable itself via RC
	assign bridge_en_nxt = (state_nxt == `HBC_ST_RUN);
	// Supply flag stays up through STOP, one cycle after the pins went idle
	assign logic_ref_nxt = (state_nxt != `HBC_ST_OFF);
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= `HBC_ST_OFF;
			cnt_r <= {`HBC_CNT_W{1'b0}};
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// ----------------------------------------
	// Device pin registers
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_n <= 1'b0;
			bridge_en <= 1'b0;
			parallel_sel <= 1'b0;
		end else begin
			sleep_n <= sleep_nxt;
			bridge_en <= bridge_en_nxt;
			// Mode strap only changed while bridge is off
			if (state_r == `HBC_ST_OFF) begin
				parallel_sel <= parallel_mode;
			end
		end
	end
	// ----------------------------------------
	// User status registers
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			running_r <= 1'b0;
			fault_seen_r <= 1'b0;
			warn_seen_r <= 1'b0;
			logic_ref_ok_r <= 1'b0;
		end else begin
			running_r <= drive_nxt;
			fault_seen_r <= ~fault_n;
			warn_seen_r <= ~overtemp_warn_n;
			logic_ref_ok_r <= logic_ref_nxt;
		end
	end
	// ----------------------------------------
	// Channel drivers
	// ----------------------------------------
	hbc_chan u_ch1 (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.drive_en(drive_nxt),
		.join_ab(parallel_sel),
		.want_a(ch1_a),
		.want_b(ch1_b),
		.pwm_in_a(pwm1_in_a),
		.pwm_in_b(pwm1_in_b)
	);
	hbc_chan u_ch2 (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.drive_en(drive_nxt),
		.join_ab(parallel_sel),
		.want_a(ch2_a),
		.want_b(ch2_b),
		.pwm_in_a(pwm2_in_a),
		.pwm_in_b(pwm2_in_b)
	);
endmodule // hbc_ctrl

// ==== src/hbc_map.vh ====
`ifndef HBC_MAP_VH
`define HBC_MAP_VH
// ----------------------------------------
// Timing counts at 100 MHz
// ----------------------------------------
`define HBC_CLK_PERIOD_NS 10
`define HBC_SUPPLY_WAIT_US 1000
`define HBC_REG_WAIT_US 1000
`define HBC_TOGGLE_LOW_NS 1000
`define HBC_SUPPLY_WAIT_CYC ((`HBC_SUPPLY_WAIT_US * 1000) / `HBC_CLK_PERIOD_NS)
`define HBC_REG_WAIT_CYC ((`HBC_REG_WAIT_US * 1000) / `HBC_CLK_PERIOD_NS)
`define HBC_TOGGLE_LOW_CYC ((`HBC_TOGGLE_LOW_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_CNT_W 20
// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define HBC_ST_OFF 3'h0
`define HBC_ST_SUPPLY 3'h1
`define HBC_ST_REGWAIT 3'h2
`define HBC_ST_RUN 3'h3
`define HBC_ST_FAULT 3'h4
`define HBC_ST_REARM 3'h5
`define HBC_ST_STOP 3'h6
`endif

// ==== src/hbc_chan.v ====
`timescale 1ns/10ps
`include "hbc_map.vh"
// ----------------------------------------
// One channel pin driver
// ----------------------------------------
module hbc_chan (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Controls
	input wire drive_en,
	input wire join_ab,
	input wire want_a,
	input wire want_b,
	// Pins
	output reg pwm_in_a,
	output reg pwm_in_b
);
	// Pair 1/1 is unused outside parallel mode, so it falls back to dump
	wire both_hi;
	assign both_hi = want_a & want_b & ~join_ab;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_in_a <= 1'b0;
			pwm_in_b <= 1'b0;
		end else if (!drive_en) begin
			pwm_in_a <= 1'b0;
			pwm_in_b <= 1'b0;
		end else begin
			pwm_in_a <= want_a & ~both_hi;
			pwm_in_b <= (join_ab ? want_a : want_b) & ~both_hi;
		end
	end
endmodule // hbc_chan

// ==== tb/hbc_sva.sv ====
`timescale 1ns/10ps
module hbc_sva (
	// Clock and user side
	input wire sys_clk,
	input wire resetn,
	input wire power_on,
	input wire auto_recover,
	input wire running_r,
	// Device pins
	input wire fault_n,
	input wire sleep_n,
	input wire bridge_en,
	input wire parallel_sel,
	input wire pwm1_in_a,
	input wire pwm1_in_b,
	input wire pwm2_in_a,
	input wire pwm2_in_b
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire [3:0] p = {pwm1_in_a, pwm1_in_b, pwm2_in_a, pwm2_in_b};
	wire f = running_r && !fault_n;
	a_sleep_first: assert property (bridge_en |-> sleep_n) else $error("order");
	a_en_late: assert property ($rose(sleep_n) |-> !bridge_en [*2]) else $error("early");
	a_idle_pins: assert property (!bridge_en |-> !p) else $error("idle");
	a_off_pins: assert property (!power_on |=> !p) else $error("off");
	a_par_join: assert property (parallel_sel |-> p[3] == p[2] && p[1] == p[0]) else $error("join");
	a_pair_unused: assert property (!parallel_sel |-> !(&p[3:2]) && !(&p[1:0])) else $error("pair");
	a_fault_gate: assert property (f |-> ##[1:2] !p) else $error("gate");
	a_fault_drop: assert property (f && !auto_recover |=> !bridge_en [*8]) else $error("drop");
	a_auto_hold: assert property (f && auto_recover && power_on |=> bridge_en) else $error("hold");
	c_up: cover property ($rose(bridge_en));
	c_fault: cover property ($fell(fault_n));
	c_par: cover property (parallel_sel && p[3]);
	c_auto: cover property (auto_recover && !fault_n && bridge_en);
endmodule // hbc_sva
bind hbc_ctrl hbc_sva u_sva (.*);

// ==== tb/hbc_dev_model.sv ====
`timescale 1ns/10ps
module hbc_dev_model (
	// Pins from controller
	input wire sleep_n,
	input wire bridge_en,
	input wire [3:0] pw,
	// Conditions and outputs
	input wire sup,
	input wire trip,
	input wire hot,
	output wire fault_oe,
	output wire warn_oe,
	output wire [7:0] sw
);
	reg lat_r = 1'b0;
	wire off = !(bridge_en && sleep_n && sup) || lat_r;
	// Latch clears only on a fresh enable rise
	always @(posedge trip or posedge bridge_en) lat_r <= trip;
	assign fault_oe = lat_r;
	assign warn_oe = hot;
	assign sw = off ? 8'h00 : {pw[3:2], ~pw[3:2], pw[1:0], ~pw[1:0]};
endmodule // hbc_dev_model

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	reg sys_clk = 0, resetn = 0, power_on = 0, auto_recover = 0, parallel_mode = 0, trip = 0, hot = 0, sup = 1;
	reg ch1_a = 0, ch1_b = 0, ch2_a = 0, ch2_b = 0;
	reg [1:0] q;
	wire running_r, fault_seen_r, warn_seen_r, logic_ref_ok_r, sleep_n, bridge_en, parallel_sel, fault_oe, warn_oe;
	wire pwm1_in_a, pwm1_in_b, pwm2_in_a, pwm2_in_b;
	wire [7:0] sw;
	wire [3:0] pw = {pwm1_in_a, pwm1_in_b, pwm2_in_a, pwm2_in_b};
	// Pull-ups on open-drain pins
	wire fault_n = !fault_oe;
	wire overtemp_warn_n = !warn_oe;
	// RC network of auto recovery: fault pin holds the enable node low a while
	reg [4:0] rc_cnt = 5'h00;
	wire dev_en = bridge_en && (rc_cnt == 5'h00);
	always @(posedge sys_clk) begin
		if (rc_cnt != 5'h00) rc_cnt <= rc_cnt - 5'h01;
		else if (auto_recover && fault_oe) rc_cnt <= 5'h14;
	end
	integer n_errors = 0, cmp_count = 0, i;
	hbc_ctrl #(.SUPPLY_WAIT_CYC(10), .REG_WAIT_CYC(10)) DUT (.*);
	hbc_dev_model M (.sleep_n(sleep_n), .bridge_en(dev_en), .pw(pw), .sup(sup), .trip(trip), .hot(hot),
		.fault_oe(fault_oe), .warn_oe(warn_oe), .sw(sw));
	task wt(input integer n); begin
		repeat (n) @(posedge sys_clk);
		#1;
	end endtask
	task chk(input [7:0] g, e); begin
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	end endtask
	task end_sim; begin
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	end endtask
	task t_up; begin
		power_on = 1;
		for (i = 0; i < 40 && sleep_n !== 1'b1; i = i + 1) wt(1);
		chk(bridge_en, 8'h00);
		for (i = 0; i < 40 && bridge_en !== 1'b1; i = i + 1) wt(1);
		chk({sleep_n, sw[7:4]}, 8'h13);
		wt(4);
		$display("test up done");
	end endtask
	task t_dec; begin
		for (i = 0; i < 4; i = i + 1) begin
			{ch1_a, ch1_b, ch2_a, ch2_b} = {i[1:0], i[1:0]};
			q = (i == 3) ? 2'h0 : i[1:0];
			wt(3);
			chk(sw, {q, ~q, q, ~q});
		end
		$display("test decode done");
	end endtask
	task t_flt; begin
		{ch1_a, ch1_b, ch2_a, ch2_b} = 4'hA;
		trip = 1;
		hot = 1;
		wt(3);
		chk({fault_n, fault_seen_r, warn_seen_r, sw[7:4]}, 8'h30);
		trip = 0;
		hot = 0;
		wt(20);
		chk({fault_n, bridge_en}, 8'h00);
		for (i = 0; i < 300 && bridge_en !== 1'b1; i = i + 1) wt(1);
		wt(4);
		chk({fault_n, sw[7:4]}, 8'h19);
		sup = 0;
		wt(1);
		chk(sw, 8'h00);
		sup = 1;
		wt(1);
		chk(sw, 8'h99);
		$display("test fault done");
	end endtask
	task t_auto; begin
		auto_recover = 1;
		trip = 1;
		wt(3);
		chk({fault_n, running_r, bridge_en, sw[7:4]}, 8'h10);
		wt(40);
		chk({fault_n, running_r, bridge_en, sw[7:4]}, 8'h10);
		trip = 0;
		wt(50);
		chk({fault_n, running_r, bridge_en, sw[7:4]}, 8'h79);
		auto_recover = 0;
		$display("test auto done");
	end endtask
	task t_off; begin
		power_on = 0;
		wt(1);
		chk({logic_ref_ok_r, sleep_n, bridge_en, pw}, 8'h40);
		wt(2);
		chk({logic_ref_ok_r, sleep_n, bridge_en, pw}, 8'h00);
		chk(sw, 8'h00);
		parallel_mode = 1;
		wt(2);
		t_up;
		chk({pw, sw[7:4]}, 8'hFC);
		$display("test parallel done");
	end endtask
	initial forever #5 sys_clk = !sys_clk;
	initial begin
		#50000;
		n_errors = n_errors + 1;
		end_sim;
	end
	initial begin
		wt(16);
		resetn = 1;
		wt(3);
		t_up;
		t_dec;
		t_flt;
		t_auto;
		t_off;
		end_sim;
	end
endmodule // testbench
